// *** hdl/dbg_unit_defs.vh ***
// Purpose: Constants for the debug breakpoint and watchpoint unit.
// Assumes: Register offsets are word indexes; byte address is four times the index.
// Notes: Field masks mark the writable bits of each control register.
`ifndef DBG_UNIT_DEFS_VH
`define DBG_UNIT_DEFS_VH

`define IDX_INT_TYPE 8'h15
`define IDX_INT_DATA 8'h16
`define IDX_STOP_MASK 8'h18
`define IDX_SCRATCH 8'h20
`define IDX_IB_ADDR 8'h30
`define IDX_IB_CTL 8'h40
`define IDX_DW_ADDR1 8'h50
`define IDX_DW_ADDR2 8'h60
`define IDX_DW_CTL 8'h70
`define IDX_RW_MASK 8'h80
`define IDX_RW_VALUE 8'h90
`define IDX_RW_CTL 8'h9c

`define IB_CTL_MASK 32'h00ff_0003
`define DW_CTL_MASK 32'h00ff_0007
`define RW_CTL_MASK 32'h00ff_0003
`define INT_TYPE_MASK 32'h0003_ff07

`define CTL_EN_BIT 0
`define CTL_SENSE_BIT 1
`define CTL_LOAD_BIT 2
`define CTL_THREAD_LSB 16

`define CAUSE_IBREAK 3'h3
`define CAUSE_DWATCH 3'h4
`define CAUSE_RWATCH 3'h5

`endif

// *** hdl/debug_breakpoint_watchpoint_unit.v ***
// Purpose: Stop mask, shared scratch, breakpoints and watchpoints for a tile debugger.
// Assumes: Core event inputs are on clk; at most one of each kind per cycle.
// Notes: Registers sit on classic Wishbone, word index on wb_adr_i[9:2].
`timescale 1ns/1ps
`include "dbg_unit_defs.vh"

module debug_breakpoint_watchpoint_unit (
	input wire clk,
	input wire sys_rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire cfg_scratch_we,
	input wire [2:0] cfg_scratch_sel,
	input wire [31:0] cfg_scratch_wdata,
	output wire [31:0] cfg_scratch_rdata,
	input wire debug_mode,
	output reg [7:0] thread_run_allow,
	input wire pc_valid,
	input wire [2:0] pc_thread,
	input wire [31:0] program_counter,
	input wire mem_valid,
	input wire mem_load,
	input wire [2:0] mem_thread,
	input wire [31:0] mem_addr,
	input wire res_valid,
	input wire [2:0] res_thread,
	input wire [31:0] res_id,
	output reg debug_irq
);

	reg [7:0] stop_mask_q;
	reg [31:0] scratch_q [0:7];
	reg [31:0] ib_addr_q [0:3];
	reg [31:0] ib_ctl_q [0:3];
	reg [31:0] dw_a1_q [0:3];
	reg [31:0] dw_a2_q [0:3];
	reg [31:0] dw_ctl_q [0:3];
	reg [31:0] rw_mask_q [0:3];
	reg [31:0] rw_val_q [0:3];
	reg [31:0] rw_ctl_q [0:3];
	reg [31:0] int_type_q;
	reg [31:0] int_data_q;
	reg [31:0] rd_d;
	wire [3:0] ib_hit;
	wire [3:0] dw_hit;
	wire [3:0] rw_hit;
	wire [7:0] idx;
	wire [31:0] bmask;
	wire [31:0] stop_merge;
	wire req;
	wire wr;
	integer i;

	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign cfg_scratch_rdata = scratch_q[cfg_scratch_sel];
	assign stop_merge = merge({24'h00_0000, stop_mask_q}, wb_dat_i, bmask);

	function [31:0] merge;
		input [31:0] old;
		input [31:0] neu;
		input [31:0] m;
		begin
			merge = (old & ~m) | (neu & m);
		end
	endfunction

	function [1:0] lowest;
		input [3:0] h;
		begin
			if (h[0]) begin
				lowest = 2'd0;
			end else if (h[1]) begin
				lowest = 2'd1;
			end else if (h[2]) begin
				lowest = 2'd2;
			end else begin
				lowest = 2'd3;
			end
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_match
			wire [31:0] ic;
			wire [31:0] dc;
			wire [31:0] rc;
			wire d_ca;
			wire d_cb;
			wire d_cond;
			wire r_eq;
			assign ic = ib_ctl_q[g];
			assign dc = dw_ctl_q[g];
			assign rc = rw_ctl_q[g];
			assign ib_hit[g] = pc_valid & ic[`CTL_EN_BIT]
				& ic[`CTL_THREAD_LSB + pc_thread]
				& ((program_counter == ib_addr_q[g]) ^ ic[`CTL_SENSE_BIT]);
			assign d_ca = mem_addr >= dw_a1_q[g];
			assign d_cb = mem_addr <= dw_a2_q[g];
			assign d_cond = dc[`CTL_SENSE_BIT] ? (d_ca | d_cb) : (d_ca & d_cb);
			assign dw_hit[g] = mem_valid & dc[`CTL_EN_BIT]
				& dc[`CTL_THREAD_LSB + mem_thread]
				& (~mem_load | dc[`CTL_LOAD_BIT])
				& d_cond;
			assign r_eq = (res_id & rw_mask_q[g]) == rw_val_q[g];
			assign rw_hit[g] = res_valid & rc[`CTL_EN_BIT]
				& rc[`CTL_THREAD_LSB + res_thread]
				& (rc[`CTL_SENSE_BIT] ? ~r_eq : r_eq);
		end
	endgenerate

	// Read multiplexer; unmapped indexes read as zero.
	always @* begin
		rd_d = 32'h0000_0000;
		if (idx == `IDX_INT_TYPE) begin
			rd_d = int_type_q;
		end else if (idx == `IDX_INT_DATA) begin
			rd_d = int_data_q;
		end else if (idx == `IDX_STOP_MASK) begin
			rd_d = {24'h00_0000, stop_mask_q};
		end else if (idx[7:3] == `IDX_SCRATCH >> 3) begin
			rd_d = scratch_q[idx[2:0]];
		end else if (idx[7:2] == `IDX_IB_ADDR >> 2) begin
			rd_d = ib_addr_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_IB_CTL >> 2) begin
			rd_d = ib_ctl_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_DW_ADDR1 >> 2) begin
			rd_d = dw_a1_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_DW_ADDR2 >> 2) begin
			rd_d = dw_a2_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_DW_CTL >> 2) begin
			rd_d = dw_ctl_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_RW_MASK >> 2) begin
			rd_d = rw_mask_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_RW_VALUE >> 2) begin
			rd_d = rw_val_q[idx[1:0]];
		end else if (idx[7:2] == `IDX_RW_CTL >> 2) begin
			rd_d = rw_ctl_q[idx[1:0]];
		end
	end

	// Bus slave, register writes and trigger capture.
	always @(posedge clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			stop_mask_q <= 8'h00;
			int_type_q <= 32'h0000_0000;
			int_data_q <= 32'h0000_0000;
			debug_irq <= 1'b0;
			thread_run_allow <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				scratch_q[i] <= 32'h0000_0000;
			end
			for (i = 0; i < 4; i = i + 1) begin
				ib_addr_q[i] <= 32'h0000_0000;
				ib_ctl_q[i] <= 32'h0000_0000;
				dw_a1_q[i] <= 32'h0000_0000;
				dw_a2_q[i] <= 32'h0000_0000;
				dw_ctl_q[i] <= 32'h0000_0000;
				rw_mask_q[i] <= 32'h0000_0000;
				rw_val_q[i] <= 32'h0000_0000;
				rw_ctl_q[i] <= 32'h0000_0000;
			end
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_d : 32'h0000_0000;
			thread_run_allow <= debug_mode ? 8'hff : ~stop_mask_q;
			if (cfg_scratch_we) begin
				scratch_q[cfg_scratch_sel] <= cfg_scratch_wdata;
			end
			if (wr) begin
				if (idx == `IDX_INT_TYPE) begin
					int_type_q <= merge(int_type_q, wb_dat_i, bmask & `INT_TYPE_MASK);
				end else if (idx == `IDX_INT_DATA) begin
					int_data_q <= merge(int_data_q, wb_dat_i, bmask);
				end else if (idx == `IDX_STOP_MASK) begin
					stop_mask_q <= stop_merge[7:0];
				end else if (idx[7:3] == `IDX_SCRATCH >> 3) begin
					scratch_q[idx[2:0]] <= merge(scratch_q[idx[2:0]], wb_dat_i, bmask);
				end else if (idx[7:2] == `IDX_IB_ADDR >> 2) begin
					ib_addr_q[idx[1:0]] <= merge(ib_addr_q[idx[1:0]], wb_dat_i, bmask);
				end else if (idx[7:2] == `IDX_IB_CTL >> 2) begin
					ib_ctl_q[idx[1:0]] <= merge(ib_ctl_q[idx[1:0]], wb_dat_i,
						bmask & `IB_CTL_MASK);
				end else if (idx[7:2] == `IDX_DW_ADDR1 >> 2) begin
					dw_a1_q[idx[1:0]] <= merge(dw_a1_q[idx[1:0]], wb_dat_i, bmask);
				end else if (idx[7:2] == `IDX_DW_ADDR2 >> 2) begin
					dw_a2_q[idx[1:0]] <= merge(dw_a2_q[idx[1:0]], wb_dat_i, bmask);
				end else if (idx[7:2] == `IDX_DW_CTL >> 2) begin
					dw_ctl_q[idx[1:0]] <= merge(dw_ctl_q[idx[1:0]], wb_dat_i,
						bmask & `DW_CTL_MASK);
				end else if (idx[7:2] == `IDX_RW_MASK >> 2) begin
					rw_mask_q[idx[1:0]] <= merge(rw_mask_q[idx[1:0]], wb_dat_i, bmask);
				end else if (idx[7:2] == `IDX_RW_VALUE >> 2) begin
					rw_val_q[idx[1:0]] <= merge(rw_val_q[idx[1:0]], wb_dat_i, bmask);
				end else if (idx[7:2] == `IDX_RW_CTL >> 2) begin
					rw_ctl_q[idx[1:0]] <= merge(rw_ctl_q[idx[1:0]], wb_dat_i,
						bmask & `RW_CTL_MASK);
				end
			end
			// Triggers are ignored in debug mode; a capture wins over a bus write.
			debug_irq <= ~debug_mode & (|ib_hit | |dw_hit | |rw_hit);
			if (~debug_mode) begin
				if (|ib_hit) begin
					int_type_q <= {14'h0000, lowest(ib_hit), 5'h00, pc_thread,
						5'h00, `CAUSE_IBREAK};
				end else if (|dw_hit) begin
					int_type_q <= {14'h0000, lowest(dw_hit), 5'h00, mem_thread,
						5'h00, `CAUSE_DWATCH};
					int_data_q <= mem_addr;
				end else if (|rw_hit) begin
					int_type_q <= {14'h0000, lowest(rw_hit), 5'h00, res_thread,
						5'h00, `CAUSE_RWATCH};
					int_data_q <= res_id;
				end
			end
		end
	end

endmodule // debug_breakpoint_watchpoint_unit

// *** test/dbg_unit_monitor.sv ***
// Purpose: Port checks for the debug unit.
// Assumes: One clock and a synchronous active-high reset.
// Notes: Bound to every unit instance.
`timescale 1ns/1ps
`include "dbg_unit_defs.vh"
module dbg_unit_monitor (
	input clk, input sys_rst, input wb_cyc_i, input wb_stb_i, input wb_we_i,
	input [31:0] wb_adr_i, input [3:0] wb_sel_i, input [31:0] wb_dat_i, input wb_ack_o,
	input cfg_scratch_we, input [2:0] cfg_scratch_sel, input [31:0] cfg_scratch_wdata,
	input [31:0] cfg_scratch_rdata, input debug_mode, input [7:0] thread_run_allow,
	input pc_valid, input mem_valid, input res_valid, input debug_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_scratch_shared: assert property (cfg_scratch_we && !(wb_cyc_i && wb_we_i) ##1
		cfg_scratch_sel == $past(cfg_scratch_sel) |-> cfg_scratch_rdata == $past(cfg_scratch_wdata))
		else $error("scratch write lost");
	chk_stop_mask: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
		&& wb_sel_i[0] && wb_adr_i[9:2] == `IDX_STOP_MASK && !debug_mode ##1 !debug_mode
		|=> thread_run_allow == ~$past(wb_dat_i[7:0], 2)) else $error("stop mask not applied");
	chk_debug_run: assert property (debug_mode && !$past(sys_rst) |=> thread_run_allow == 8'hff)
		else $error("thread held in debug");
	chk_quiet_debug: assert property (debug_mode |=> !debug_irq)
		else $error("trigger in debug");
	chk_irq_source: assert property (!(pc_valid || mem_valid || res_valid) |=> !debug_irq)
		else $error("trigger without event");
	cover property (debug_irq);
	cover property (wb_ack_o && $past(wb_we_i));
	cover property (debug_mode ##1 !debug_mode);
endmodule // dbg_unit_monitor
bind debug_breakpoint_watchpoint_unit dbg_unit_monitor mon (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .cfg_scratch_we, .cfg_scratch_sel,
	.cfg_scratch_wdata, .cfg_scratch_rdata, .debug_mode, .thread_run_allow, .pc_valid,
	.mem_valid, .res_valid, .debug_irq);

// *** test/core_event_model.sv ***
// Purpose: Logical cores issuing instructions, memory accesses and resource uses.
// Assumes: Each issue stands for one clock cycle.
// Notes: Released data lines show the inverse of their last value; valid lines return to zero.
`timescale 1ns/1ps
module core_event_model (
	input clk, output reg pc_valid = '0, output reg [2:0] pc_thread = '0,
	output reg [31:0] program_counter = '0, output reg mem_valid = '0, output reg mem_load = '0,
	output reg [2:0] mem_thread = '0, output reg [31:0] mem_addr = '0, output reg res_valid = '0,
	output reg [2:0] res_thread = '0, output reg [31:0] res_id = '0
);
	task issue(input [2:0] v, input ld, input [2:0] t, input [31:0] pc, input [31:0] ma,
		input [31:0] ri);
		{res_valid, mem_valid, pc_valid} <= v;
		{pc_thread, mem_thread, res_thread} <= {3{t}};
		{program_counter, mem_addr, res_id, mem_load} <= {pc, ma, ri, ld};
		@(posedge clk);
		{res_valid, mem_valid, pc_valid} <= 3'h0;
		{pc_thread, mem_thread, res_thread} <= ~{3{t}};
		{program_counter, mem_addr, res_id, mem_load} <= ~{pc, ma, ri, ld};
	endtask
endmodule // core_event_model

// *** test/debug_breakpoint_watchpoint_unit_tb.sv ***
// Purpose: Self-checking bench for the debug unit.
// Assumes: Wishbone answers with ack; reset clears every register.
// Notes: A register model predicts every read and trigger.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module debug_breakpoint_watchpoint_unit_tb;
	logic clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cfg_scratch_we = 0;
	logic debug_mode = 0, wb_ack_o, debug_irq, pc_valid, mem_valid, mem_load, res_valid;
	logic [31:0] wb_adr_i = 0, wb_dat_i = 0, cfg_scratch_wdata = 0, wb_dat_o, cfg_scratch_rdata;
	logic [31:0] res_id, program_counter, mem_addr, rd, m [0:255];
	logic [2:0] cfg_scratch_sel = 0, pc_thread, mem_thread, res_thread;
	logic [3:0] wb_sel_i = 4'hf;
	logic [7:0] thread_run_allow, a;
	logic [31:0] v, ty, dt, c, d16;
	logic hit;
	int bad_count = 0, checks_done = 0;
	debug_breakpoint_watchpoint_unit dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_scratch_we, .cfg_scratch_sel,
		.cfg_scratch_wdata, .cfg_scratch_rdata, .debug_mode, .thread_run_allow, .pc_valid,
		.pc_thread, .program_counter, .mem_valid, .mem_load, .mem_thread, .mem_addr, .res_valid,
		.res_thread, .res_id, .debug_irq);
	core_event_model cores (.clk, .pc_valid, .pc_thread, .program_counter, .mem_valid, .mem_load,
		.mem_thread, .mem_addr, .res_valid, .res_thread, .res_id);
	initial begin
		forever #4 clk = ~clk;
	end
	function automatic [31:0] msk(input [7:0] x);
		case (x) inside
			8'h15: return 32'h0003_ff07;
			8'h18: return 32'h0000_00ff;
			[8'h40:8'h43], [8'h9c:8'h9f]: return 32'h00ff_0003;
			[8'h70:8'h73]: return 32'h00ff_0007;
			8'h16, [8'h20:8'h33], [8'h50:8'h63], [8'h80:8'h93]: return 32'hffff_ffff;
			default: return 32'h0000_0000;
		endcase
	endfunction
	task wb(input w, input [7:0] x, input [31:0] d);
		int n;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, 22'h0, x, 2'h0, d};
		n = 0;
		do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50 && wb_ack_o !== 1'b1) bad_count++;
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk);
	endtask
	task reg_wr(input [7:0] x, input [31:0] d);
		wb(1, x, d);
		m[x] = d & msk(x);
	endtask
	task chk_rd(input [7:0] x);
		wb(0, x, 0);
		`CHK("register", m[x], rd)
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#(8 * 30000);
		bad_count++;
		wrap_up;
	end
	initial begin
		void'($urandom(29));
		foreach (m[i]) m[i] = 0;
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		for (int i = 0; i < 256; i++) chk_rd(i);
		$display("reset values done");
		for (int s = 0; s < 8; s++) begin
			reg_wr(8'h20 + s, $urandom);
			cfg_scratch_sel <= s;
			@(posedge clk);
			`CHK("scratch", m[8'h20 + s], cfg_scratch_rdata)
			{cfg_scratch_we, cfg_scratch_sel, cfg_scratch_wdata} <= {1'b1, 3'h7 - s[2:0], $urandom};
			@(posedge clk);
			cfg_scratch_we <= 0;
			m[8'h27 - s] = cfg_scratch_wdata;
			chk_rd(8'h27 - s);
		end
		reg_wr(8'h18, $urandom);
		`CHK("run", ~m[8'h18][7:0], thread_run_allow)
		debug_mode <= 1;
		repeat (2) @(posedge clk);
		`CHK("run", 8'hff, thread_run_allow)
		debug_mode <= 0;
		repeat (2) @(posedge clk);
		`CHK("run", ~m[8'h18][7:0], thread_run_allow)
		reg_wr(8'h18, 0);
		$display("stop mask done");
		repeat (300) begin
			debug_mode <= ($urandom_range(0, 9) == 0);
			a = {4'h3 + $urandom_range(0, 6), 4'h0} + $urandom_range(0, 3);
			if (a[7:4] == 4'h9 && $urandom_range(0, 1)) a = a + 8'h0c;
			v = (a[7:4] == 4'h4 || a[7:4] == 4'h7 || a >= 8'h9c) ? $urandom | 1 : $urandom_range(0, 3);
			reg_wr(a, v);
			chk_rd(a);
			{c, ty, dt} = {$urandom, $urandom_range(0, 3), $urandom_range(0, 3)};
			v = $urandom_range(0, 3);
			hit = 0;
			d16 = m[8'h16];
			for (int k = 2; k >= 0; k--) for (int i = 3; i >= 0; i--) begin
				a = (k == 0 ? 8'h40 : k == 1 ? 8'h70 : 8'h9c) + i;
				if (c[k] && m[a][0] && m[a][16 + c[5:3]] && !debug_mode && (k == 0
					? (v == m[8'h30 + i]) ^ m[a][1]
					: k == 1 ? (!c[6] || m[a][2]) && (m[a][1]
					? ty >= m[8'h50 + i] || ty <= m[8'h60 + i]
					: ty >= m[8'h50 + i] && ty <= m[8'h60 + i])
					: ((dt & m[8'h80 + i]) == m[8'h90 + i]) ^ m[a][1])) begin
					hit = 1;
					m[8'h15] = {14'h0, i[1:0], 5'h0, c[5:3], 5'h0, 3'h3 + k[2:0]};
					m[8'h16] = k == 0 ? d16 : k == 1 ? ty : dt;
				end
			end
			cores.issue(c[2:0], c[6], c[5:3], v, ty, dt);
			#1 `CHK("debug_irq", hit, debug_irq)
			@(posedge clk);
			chk_rd(8'h15);
			chk_rd(8'h16);
		end
		$display("trigger loop done");
		wrap_up;
	end
endmodule // debug_breakpoint_watchpoint_unit_tb
